// ### test/hcp_cap_params_bench.sv
// Self-checking bench for the capability parameter word block.
// Assumes reads answer one cycle later and writes change nothing.
`timescale 1ns/100ps
`default_nettype none
module hcp_cap_params_bench;
  import hcp_pkg::*;
  localparam logic [31:0] WORD = 32'h0068_0ff5;
  localparam logic [7:0] CAP = CAP_PARAMS_ONE_OFFSET;
  logic clk, rst, wr, rd, upu, ppw, piw, lre, latency_tolerance_messages, sts;
  logic [ADDR_W-1:0] addr;
  logic [31:0] wdata, rdata;
  logic [6:0] cxb, scb;
  int err_count, checked;
  hcp_cap_params #(.CTX_WIDE(1'b1), .PORT_POWER(1'b0), .PORT_IND(1'b1),
    .NO_SSID(1'b1), .PSA_EXP(4'h0)) hcp_cap_params_inst (.clk(clk), .rst(rst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .upper_ptr_used(upu), .context_bytes(cxb), .stream_context_bytes(scb),
    .port_power_flag_writable(ppw), .port_indicator_writable(piw),
    .light_reset_trigger_enable(lre),
    .latency_tolerance_messages_enable(latency_tolerance_messages), .streams_supported(sts));
  task automatic chk_word(string n, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk_word
  task automatic chk_num(string n, logic [6:0] e, logic [6:0] g);
    checked++;
    if (g !== e)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk_num
  task automatic chk_flag(string n, logic e, logic g);
    checked++;
    if (g !== e)
    begin
      err_count++;
      $display("Error %s expected %b seen %b", n, e, g);
    end
  endtask : chk_flag
  task automatic reg_wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(logic [7:0] a, logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk_word("rdata", e, rdata);
  endtask : reg_rd
  task automatic chk_outs(logic on);
    chk_flag("upper_ptr_used", on, upu);
    chk_num("context_bytes", on ? 7'h40 : 7'h00, cxb);
    chk_num("stream_context_bytes", on ? 7'h10 : 7'h00, scb);
    chk_flag("port_power_flag_writable", 1'b0, ppw);
    chk_flag("port_indicator_writable", on, piw);
    chk_flag("light_reset_trigger_enable", on, lre);
    chk_flag("latency_tolerance_messages_enable", on, latency_tolerance_messages);
    chk_flag("streams_supported", 1'b0, sts);
  endtask : chk_outs
  task automatic give_verdict;
    $display("Comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    repeat (500) @(posedge clk);
    err_count++;
    give_verdict;
  end
  initial
  begin
    {rst, wr, rd, addr, wdata} = {3'b100, 8'h00, 32'h0000_0000};
    repeat (4) @(posedge clk);
    #1;
    chk_outs(1'b0);
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk_outs(1'b1);
    reg_rd(CAP, WORD);
    @(posedge clk);
    #1;
    chk_word("rdata", READ_ZERO, rdata);
    reg_wr(CAP, 32'hffff_ffff);
    reg_rd(CAP, WORD);
    reg_wr(CAP, 32'h0000_0000);
    reg_rd(CAP, WORD);
    reg_rd(8'h14, READ_ZERO);
    reg_rd(8'h11, READ_ZERO);
    @(posedge clk);
    rd <= 1'b1;
    addr <= CAP;
    @(posedge clk);
    addr <= 8'h14;
    #1;
    chk_word("rdata", WORD, rdata);
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk_word("rdata", READ_ZERO, rdata);
    chk_outs(1'b1);
    give_verdict;
  end
endmodule : hcp_cap_params_bench
`default_nettype wire

// ### verilog/hcp_cap_params.sv
// Read-only capability parameter word with derived gating outputs.
// Assumes a synchronous register port; reads answer one cycle later.
//
// How it works
// [RULE_01] Bit 0 reports wide pointers; when zero, upper pointer bits are ignored.
// [RULE_02] Bit 2 picks 64-byte contexts when one, 32-byte when zero.
// [RULE_03] Stream context size never follows the context size bit.
// [RULE_04] Bit 3 reports port power switches and gates the port power flag.
// [RULE_05] Bit 4 enables a writable port indicator field in port registers.
// [RULE_06] Bit 5 reports light reset support and gates the light reset trigger.
// [RULE_07] Bit 6 reports latency tolerance messaging support.
// [RULE_08] Bit 7 is one when secondary stream IDs are not decoded.
// [RULE_09] Bit 8 is one when all event data blocks are parsed.
// [RULE_10] Bit 9 reports the stopped short packet completion code.
// [RULE_11] Bit 10 reports stopped length field; always one here.
// [RULE_12] Bit 11 reports frame ID matching of consecutive isoch descriptors.
// [RULE_13] Field 15:12 gives stream array exponent; zero means no streams.
// [RULE_14] Software finds extended capabilities at base plus field times four.
// [RULE_15] The word is read-only; writes change nothing.
`timescale 1ns/100ps
`default_nettype none
module hcp_cap_params
  import hcp_pkg::*;
#(
  parameter logic WIDE_ADDR = 1'b1,
  parameter logic BW_NEG = 1'b0,
  parameter logic CTX_WIDE = 1'b0,
  parameter logic PORT_POWER = 1'b1,
  parameter logic PORT_IND = 1'b0,
  parameter logic LIGHT_RESET = 1'b1,
  parameter logic LATENCY = 1'b1,
  parameter logic NO_SSID = 1'b0,
  parameter logic PARSE_ALL = 1'b1,
  parameter logic STOP_SHORT = 1'b1,
  parameter logic FRAME_ID = 1'b1,
  parameter logic [3:0] PSA_EXP = 4'h7,
  parameter logic [15:0] EXTENDED_CAP_POINTER = 16'h0068
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [hcp_pkg::ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic upper_ptr_used,
  output logic [6:0] context_bytes,
  output logic [6:0] stream_context_bytes,
  output logic port_power_flag_writable,
  output logic port_indicator_writable,
  output logic light_reset_trigger_enable,
  output logic latency_tolerance_messages_enable,
  output logic streams_supported
);
  import hcp_pkg::*;

  logic [31:0] cap_word;
  logic [31:0] next_rdata;
  logic next_upper;
  logic [6:0] next_ctx;
  logic [6:0] next_sctx;
  logic next_pp;
  logic next_pi;
  logic next_lr;
  logic next_ltm;
  logic next_streams;
  logic [31:0] rdata_q;

  // Fixed word; no path from the write port reaches it.
  always_comb
  begin
    cap_word = READ_ZERO;
    cap_word[BIT_WIDE_ADDR] = WIDE_ADDR; // RULE_01
    cap_word[BIT_BW_NEG] = BW_NEG;
    cap_word[BIT_CTX_SIZE] = CTX_WIDE; // RULE_02
    cap_word[BIT_PORT_POWER] = PORT_POWER; // RULE_04
    cap_word[BIT_PORT_IND] = PORT_IND; // RULE_05
    cap_word[BIT_LIGHT_RESET] = LIGHT_RESET; // RULE_06
    cap_word[BIT_LATENCY] = LATENCY; // RULE_07
    cap_word[BIT_NO_SSID] = NO_SSID; // RULE_08
    cap_word[BIT_PARSE_ALL] = PARSE_ALL; // RULE_09
    cap_word[BIT_STOP_SHORT] = STOP_SHORT; // RULE_10
    cap_word[BIT_STOP_LEN] = 1'b1; // RULE_11
    cap_word[BIT_FRAME_ID] = FRAME_ID; // RULE_12
    cap_word[PSA_MSB:PSA_LSB] = PSA_EXP; // RULE_13
    cap_word[EXTENDED_CAP_POINTER_MSB:EXTENDED_CAP_POINTER_LSB] = EXTENDED_CAP_POINTER; // RULE_14
  end

  always_comb
  begin
    next_rdata = READ_ZERO;
    if (rd && addr == CAP_PARAMS_ONE_OFFSET)
    begin
      next_rdata = cap_word; // RULE_15
    end
    next_upper = cap_word[BIT_WIDE_ADDR]; // RULE_01
    next_ctx = cap_word[BIT_CTX_SIZE] ? 7'(CTX_BYTES_WIDE)
                                      : 7'(CTX_BYTES_NARROW); // RULE_02
    next_sctx = 7'(STREAM_CTX_BYTES); // RULE_03
    next_pp = cap_word[BIT_PORT_POWER]; // RULE_04
    next_pi = cap_word[BIT_PORT_IND]; // RULE_05
    next_lr = cap_word[BIT_LIGHT_RESET]; // RULE_06
    next_ltm = cap_word[BIT_LATENCY]; // RULE_07
    next_streams = cap_word[PSA_MSB:PSA_LSB] != 4'h0; // RULE_13
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdata_q <= READ_ZERO;
      upper_ptr_used <= 1'b0;
      context_bytes <= 7'h00;
      stream_context_bytes <= 7'h00;
      port_power_flag_writable <= 1'b0;
      port_indicator_writable <= 1'b0;
      light_reset_trigger_enable <= 1'b0;
      latency_tolerance_messages_enable <= 1'b0;
      streams_supported <= 1'b0;
    end
    else
    begin
      rdata_q <= next_rdata;
      upper_ptr_used <= next_upper;
      context_bytes <= next_ctx;
      stream_context_bytes <= next_sctx;
      port_power_flag_writable <= next_pp;
      port_indicator_writable <= next_pi;
      light_reset_trigger_enable <= next_lr;
      latency_tolerance_messages_enable <= next_ltm;
      streams_supported <= next_streams;
    end
  end

  assign rdata = rdata_q;

  read_answer_a: assert property (@(posedge clk) disable iff (rst)
    rd && addr == CAP_PARAMS_ONE_OFFSET |=> rdata == cap_word)
    else $error("Capability word read returned wrong data."); // RULE_15
  read_other_a: assert property (@(posedge clk) disable iff (rst)
    !(rd && addr == CAP_PARAMS_ONE_OFFSET) |=> rdata == READ_ZERO)
    else $error("Read data not zero outside a mapped read."); // RULE_15
  write_ignored_a: assert property (@(posedge clk) disable iff (rst)
    wr ##1 rd && addr == CAP_PARAMS_ONE_OFFSET |=> rdata == cap_word)
    else $error("Write altered the capability word."); // RULE_15
  ctx_size_a: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |-> context_bytes ==
      (cap_word[BIT_CTX_SIZE] ? 7'd64 : 7'd32))
    else $error("Context size does not follow its bit."); // RULE_02
  stream_ctx_a: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |-> stream_context_bytes == 7'd16)
    else $error("Stream context size moved."); // RULE_03
  stop_len_a: assert property (@(posedge clk) disable iff (rst)
    rd && addr == CAP_PARAMS_ONE_OFFSET |=> rdata[10])
    else $error("Stopped length capability not reported."); // RULE_11
  gates_a: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |-> port_power_flag_writable == cap_word[3]
      && port_indicator_writable == cap_word[4]
      && light_reset_trigger_enable == cap_word[5]
      && latency_tolerance_messages_enable == cap_word[6])
    else $error("Gating output disagrees with capability."); // RULE_04
  streams_a: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |-> streams_supported == (cap_word[15:12] != 4'h0))
    else $error("Stream support disagrees with exponent."); // RULE_13
  wide_ptr_a: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |-> upper_ptr_used == cap_word[0])
    else $error("Upper pointer use disagrees with bit 0."); // RULE_01

  rd_wide_bit_a: assert property ( // RULE_01
    @(posedge clk) disable iff (rst)
    rd && addr == CAP_PARAMS_ONE_OFFSET
    |=> rdata[BIT_WIDE_ADDR] == WIDE_ADDR)
    else $error("Wide pointer bit read wrong.");

  rd_bw_bit_a: assert property ( // RULE_15
    @(posedge clk) disable iff (rst)
    rd && addr == CAP_PARAMS_ONE_OFFSET
    |=> rdata[BIT_BW_NEG] == BW_NEG)
    else $error("Bandwidth bit read wrong.");

  rd_ctx_bit_a: assert property ( // RULE_02
    @(posedge clk) disable iff (rst)
    rd && addr == CAP_PARAMS_ONE_OFFSET
    |=> rdata[BIT_CTX_SIZE] == CTX_WIDE)
    else $error("Context size bit read wrong.");

  rd_power_bit_a: assert property ( // RULE_04
    @(posedge clk) disable iff (rst)
    rd && addr == CAP_PARAMS_ONE_OFFSET
    |=> rdata[BIT_PORT_POWER] == PORT_POWER)
    else $error("Port power bit read wrong.");

  rd_ind_bit_a: assert property ( // RULE_05
    @(posedge clk) disable iff (rst)
    rd && addr == CAP_PARAMS_ONE_OFFSET
    |=> rdata[BIT_PORT_IND] == PORT_IND)
    else $error("Port indicator bit read wrong.");

  rd_light_bit_a: assert property ( // RULE_06
    @(posedge clk) disable iff (rst)
    rd && addr == CAP_PARAMS_ONE_OFFSET
    |=> rdata[BIT_LIGHT_RESET] == LIGHT_RESET)
    else $error("Light reset bit read wrong.");

  rd_lat_bit_a: assert property ( // RULE_07
    @(posedge clk) disable iff (rst)
    rd && addr == CAP_PARAMS_ONE_OFFSET
    |=> rdata[BIT_LATENCY] == LATENCY)
    else $error("Latency bit read wrong.");

  rd_ssid_bit_a: assert property ( // RULE_08
    @(posedge clk) disable iff (rst)
    rd && addr == CAP_PARAMS_ONE_OFFSET
    |=> rdata[BIT_NO_SSID] == NO_SSID)
    else $error("Secondary stream bit read wrong.");

  rd_parse_bit_a: assert property ( // RULE_09
    @(posedge clk) disable iff (rst)
    rd && addr == CAP_PARAMS_ONE_OFFSET
    |=> rdata[BIT_PARSE_ALL] == PARSE_ALL)
    else $error("Parse all bit read wrong.");

  rd_short_bit_a: assert property ( // RULE_10
    @(posedge clk) disable iff (rst)
    rd && addr == CAP_PARAMS_ONE_OFFSET
    |=> rdata[BIT_STOP_SHORT] == STOP_SHORT)
    else $error("Stopped short bit read wrong.");

  rd_frame_bit_a: assert property ( // RULE_12
    @(posedge clk) disable iff (rst)
    rd && addr == CAP_PARAMS_ONE_OFFSET
    |=> rdata[BIT_FRAME_ID] == FRAME_ID)
    else $error("Frame ID bit read wrong.");

  rd_psa_field_a: assert property ( // RULE_13
    @(posedge clk) disable iff (rst)
    rd && addr == CAP_PARAMS_ONE_OFFSET
    |=> rdata[PSA_MSB:PSA_LSB] == PSA_EXP)
    else $error("Stream array field read wrong.");

  rd_extended_cap_pointer_field_a: assert property ( // RULE_14
    @(posedge clk) disable iff (rst)
    rd && addr == CAP_PARAMS_ONE_OFFSET
    |=> rdata[EXTENDED_CAP_POINTER_MSB:EXTENDED_CAP_POINTER_LSB] == EXTENDED_CAP_POINTER)
    else $error("Extended pointer field read wrong.");

  rd_unmapped_a: assert property ( // RULE_15
    @(posedge clk) disable iff (rst)
    rd && addr != CAP_PARAMS_ONE_OFFSET
    |=> rdata == READ_ZERO)
    else $error("Unmapped read returned data.");

  wr_only_zero_a: assert property ( // RULE_15
    @(posedge clk) disable iff (rst)
    wr && !rd
    |=> rdata == READ_ZERO)
    else $error("Write produced read data.");

  rd_back_back_a: assert property ( // RULE_15
    @(posedge clk) disable iff (rst)
    rd && addr == CAP_PARAMS_ONE_OFFSET ##1 rd && addr == CAP_PARAMS_ONE_OFFSET
    |=> rdata == cap_word)
    else $error("Back to back read returned wrong data.");

  rd_once_a: assert property ( // RULE_15
    @(posedge clk) disable iff (rst)
    rd && addr == CAP_PARAMS_ONE_OFFSET ##1 !rd
    |=> rdata == READ_ZERO)
    else $error("Read data stood too long.");

  power_gate_a: assert property ( // RULE_04
    @(posedge clk) disable iff (rst)
    !$past(rst)
    |-> port_power_flag_writable == PORT_POWER)
    else $error("Port power gate wrong.");

  ind_gate_a: assert property ( // RULE_05
    @(posedge clk) disable iff (rst)
    !$past(rst)
    |-> port_indicator_writable == PORT_IND)
    else $error("Port indicator gate wrong.");

  light_gate_a: assert property ( // RULE_06
    @(posedge clk) disable iff (rst)
    !$past(rst)
    |-> light_reset_trigger_enable == LIGHT_RESET)
    else $error("Light reset gate wrong.");

  lat_gate_a: assert property ( // RULE_07
    @(posedge clk) disable iff (rst)
    !$past(rst)
    |-> latency_tolerance_messages_enable == LATENCY)
    else $error("Latency gate wrong.");

  rst_rdata_a: assert property ( // RULE_15
    @(posedge clk)
    rst
    |=> rdata == READ_ZERO)
    else $error("Read data not cleared by reset.");

  rst_gates_a: assert property ( // RULE_04
    @(posedge clk)
    rst
    |=> !port_power_flag_writable && !port_indicator_writable)
    else $error("Port gates not cleared by reset.");

  rst_enables_a: assert property ( // RULE_07
    @(posedge clk)
    rst
    |=> !light_reset_trigger_enable && !latency_tolerance_messages_enable)
    else $error("Enables not cleared by reset.");

  rst_sizes_a: assert property ( // RULE_03
    @(posedge clk)
    rst
    |=> context_bytes == 7'h00 && stream_context_bytes == 7'h00)
    else $error("Sizes not cleared by reset.");

  rst_flags_a: assert property ( // RULE_13
    @(posedge clk)
    rst
    |=> !upper_ptr_used && !streams_supported)
    else $error("Flags not cleared by reset.");

  rd_len_bit_a: assert property ( // RULE_11
    @(posedge clk) disable iff (rst)
    rd && addr == CAP_PARAMS_ONE_OFFSET
    |=> rdata[BIT_STOP_LEN] == 1'b1)
    else $error("Stopped length bit read wrong.");
endmodule : hcp_cap_params
`default_nettype wire

// ### verilog/hcp_pkg.sv
// Constants for the capability parameter word block.
// Assumes a plain register port on the controller clock.
`default_nettype none
package hcp_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] CAP_PARAMS_ONE_OFFSET = 8'h10;
  localparam int BIT_WIDE_ADDR = 0;
  localparam int BIT_BW_NEG = 1;
  localparam int BIT_CTX_SIZE = 2;
  localparam int BIT_PORT_POWER = 3;
  localparam int BIT_PORT_IND = 4;
  localparam int BIT_LIGHT_RESET = 5;
  localparam int BIT_LATENCY = 6;
  localparam int BIT_NO_SSID = 7;
  localparam int BIT_PARSE_ALL = 8;
  localparam int BIT_STOP_SHORT = 9;
  localparam int BIT_STOP_LEN = 10;
  localparam int BIT_FRAME_ID = 11;
  localparam int PSA_LSB = 12;
  localparam int PSA_MSB = 15;
  localparam int EXTENDED_CAP_POINTER_LSB = 16;
  localparam int EXTENDED_CAP_POINTER_MSB = 31;
  localparam int CTX_BYTES_WIDE = 64;
  localparam int CTX_BYTES_NARROW = 32;
  localparam int STREAM_CTX_BYTES = 16;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;
endpackage : hcp_pkg
`default_nettype wire
